/* src/adc_out_fmt_pkg.sv */
// Purpose: Shared constants and types for the serial output format registers.
// Assumes: Registers sit one per 32-bit word; byte address is four times the index.
// Notes:   Reserved bits read as zero and are not stored.
`default_nettype none
package adc_out_fmt_pkg;
  // Register indices; the bus byte address is the index shifted left by two.
  localparam logic [5:0] IDX_DRIVE   = 6'h1A;
  localparam logic [5:0] IDX_RES     = 6'h1B;
  localparam logic [5:0] IDX_SKEW    = 6'h1E;
  localparam logic [5:0] IDX_STATUS  = 6'h1F;
  localparam logic [5:0] IDX_PAT_LO  = 6'h20;
  localparam logic [5:0] IDX_PAT_MID = 6'h21;
  localparam logic [5:0] IDX_PAT_HI  = 6'h22;
  localparam int unsigned ADR_W      = 8;
  // Field positions.
  localparam int unsigned HALF_DRIVE_BIT = 6;
  localparam int unsigned RESIZE_BIT     = 7;
  localparam int unsigned WIDE_BIT       = 6;
  localparam int unsigned WSEL_LSB       = 3;
  localparam int unsigned LANE_SKEW_LSB  = 2;
  localparam int unsigned CLK_SKEW_LSB   = 0;
  localparam int unsigned STAT_BUSY_BIT  = 7;
  // Reset values.
  localparam logic [7:0]  REG_RST = 8'h00;
  localparam logic [19:0] PAT_RST = 20'h00000;
  // Output width select codes and the widths they stand for.
  localparam logic [2:0] WSEL_18 = 3'h0;
  localparam logic [2:0] WSEL_16 = 3'h1;
  localparam logic [2:0] WSEL_14 = 3'h2;
  localparam logic [4:0] WIDTH_14 = 5'h0E;
  localparam logic [4:0] WIDTH_16 = 5'h10;
  localparam logic [4:0] WIDTH_18 = 5'h12;
  localparam logic [4:0] WIDTH_20 = 5'h14;
  localparam logic [4:0] WIDTH_NATIVE = WIDTH_14;
  localparam logic [4:0] PAT_MSB = 5'h13;
  // Skew codes: none, advance 50 ps, delay 50 ps, delay 100 ps.
  localparam logic [1:0] SKEW_NONE    = 2'h0;
  localparam logic [1:0] SKEW_ADV_50  = 2'h1;
  localparam logic [1:0] SKEW_DEL_50  = 2'h2;
  localparam logic [1:0] SKEW_DEL_100 = 2'h3;

  typedef enum logic [1:0] {
    DECIM_BYPASS  = 2'h0,
    DECIM_REAL    = 2'h1,
    DECIM_COMPLEX = 2'h2
  } decim_mode_t;

  typedef struct packed {
    logic        half_drive_current;
    logic [1:0]  lane_data_skew;
    logic [1:0]  bit_clock_skew;
    logic        auto_pattern;
    logic [4:0]  width;
    logic [19:0] frame_clock_pattern;
  } link_cfg_t;

  localparam link_cfg_t CFG_RST = '{1'b0, SKEW_NONE, SKEW_NONE, 1'b1, WIDTH_NATIVE, PAT_RST};
endpackage
`default_nettype wire

/* src/adc_out_fmt_regs.sv */
// Purpose: Output format registers of the serial sample link and the link-side framer.
// Assumes: Classic Wishbone on clk; the serial link runs on link_clk.
// Notes:   Configuration crosses to the link by a toggle handshake.
`default_nettype none
module adc_out_fmt_regs
  import adc_out_fmt_pkg::*;
(
  // System clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Wishbone slave
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [ADR_W-1:0]  wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [31:0]       wb_wdata,
  output logic      [31:0]       wb_rdata,
  output logic                   wb_ack,
  // Operating mode from the digital path
  input  wire decim_mode_t       decim_mode,
  // Link domain
  input  wire logic              link_clk,
  input  wire logic [19:0]       sample_word,
  output logic                   serial_data,
  output logic                   frame_clock_out,
  output logic                   frame_start,
  output logic                   half_drive_current,
  output logic      [1:0]        lane_data_skew,
  output logic      [1:0]        bit_clock_skew
);

  // Register file and bus slave.
  logic        half_q, half_d;
  logic        resize_q, resize_d;
  logic        wide_q, wide_d;
  logic [2:0]  wsel_q, wsel_d;
  logic [1:0]  lskew_q, lskew_d;
  logic [1:0]  cskew_q, cskew_d;
  logic [19:0] pat_q, pat_d;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [5:0]  idx;
  logic        wr_en;
  logic        busy;
  link_cfg_t   cfg_now;

  assign idx   = wb_adr[ADR_W-1:2];
  assign wr_en = wb_cyc && wb_stb && wb_we && !ack_q && wb_sel[0];

  always_comb begin
    half_d   = half_q;
    resize_d = resize_q;
    wide_d   = wide_q;
    wsel_d   = wsel_q;
    lskew_d  = lskew_q;
    cskew_d  = cskew_q;
    pat_d    = pat_q;
    ack_d    = wb_cyc && wb_stb && !ack_q;
    rdata_d  = 32'h00000000;
    if (wr_en) begin
      unique case (idx)
        IDX_DRIVE: begin
          half_d = wb_wdata[HALF_DRIVE_BIT];
        end
        IDX_RES: begin
          resize_d = wb_wdata[RESIZE_BIT];
          wide_d   = wb_wdata[WIDE_BIT];
          wsel_d   = wb_wdata[WSEL_LSB +: 3];
        end
        IDX_SKEW: begin
          lskew_d = wb_wdata[LANE_SKEW_LSB +: 2];
          cskew_d = wb_wdata[CLK_SKEW_LSB +: 2];
        end
        IDX_PAT_LO:  pat_d[7:0]   = wb_wdata[7:0];
        IDX_PAT_MID: pat_d[15:8]  = wb_wdata[7:0];
        IDX_PAT_HI:  pat_d[19:16] = wb_wdata[3:0];
        default: ;
      endcase
    end
    if (wb_cyc && wb_stb && !wb_we && !ack_q) begin
      unique case (idx)
        IDX_DRIVE:   rdata_d[HALF_DRIVE_BIT] = half_q;
        IDX_RES: begin
          rdata_d[RESIZE_BIT]       = resize_q;
          rdata_d[WIDE_BIT]         = wide_q;
          rdata_d[WSEL_LSB +: 3]    = wsel_q;
        end
        IDX_SKEW: begin
          rdata_d[LANE_SKEW_LSB +: 2] = lskew_q;
          rdata_d[CLK_SKEW_LSB +: 2]  = cskew_q;
        end
        IDX_STATUS: begin
          rdata_d[4:0]           = cfg_now.width;
          rdata_d[STAT_BUSY_BIT] = busy;
        end
        IDX_PAT_LO:  rdata_d[7:0] = pat_q[7:0];
        IDX_PAT_MID: rdata_d[7:0] = pat_q[15:8];
        IDX_PAT_HI:  rdata_d[3:0] = pat_q[19:16];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_q   <= 1'b0;
      resize_q <= REG_RST[RESIZE_BIT];
      wide_q   <= REG_RST[WIDE_BIT];
      wsel_q   <= WSEL_18;
      lskew_q  <= SKEW_NONE;
      cskew_q  <= SKEW_NONE;
      pat_q    <= PAT_RST;
      ack_q    <= 1'b0;
      rdata_q  <= 32'h00000000;
    end else begin
      half_q   <= half_d;
      resize_q <= resize_d;
      wide_q   <= wide_d;
      wsel_q   <= wsel_d;
      lskew_q  <= lskew_d;
      cskew_q  <= cskew_d;
      pat_q    <= pat_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
    end
  end

  assign wb_ack   = ack_q;
  assign wb_rdata = rdata_q;

  // Resolve the effective output format. An unknown width code keeps native resolution.
  function automatic logic [4:0] decode_wsel(input logic [2:0] code);
    logic [4:0] w;
    unique case (code)
      WSEL_18: w = WIDTH_18;
      WSEL_16: w = WIDTH_16;
      WSEL_14: w = WIDTH_14;
      default: w = WIDTH_NATIVE;
    endcase
    return w;
  endfunction

  always_comb begin
    cfg_now.half_drive_current  = half_q;
    cfg_now.lane_data_skew      = lskew_q;
    cfg_now.bit_clock_skew      = cskew_q;
    cfg_now.auto_pattern        = (decim_mode == DECIM_BYPASS);
    cfg_now.frame_clock_pattern = pat_q;
    if (wide_q) begin
      cfg_now.width = WIDTH_20;
    end else if (decim_mode == DECIM_BYPASS) begin
      cfg_now.width = resize_q ? decode_wsel(wsel_q) : WIDTH_NATIVE;
    end else begin
      // In decimation the field alone sets the width; resize is ignored there.
      cfg_now.width = decode_wsel(wsel_q);
    end
  end

  // Clock crossing, system side: a new snapshot is offered only when the last one
  // was taken, so the held word never changes while the link reads it.
  link_cfg_t hold_q, hold_d;
  logic      req_q, req_d;
  logic      ack_s1_q, ack_s2_q, ack_s3_q;
  logic      link_ack_q;

  assign busy = req_q ^ ack_s3_q;

  always_comb begin
    hold_d = hold_q;
    req_d  = req_q;
    if (!busy && (cfg_now != hold_q)) begin
      hold_d = cfg_now;
      req_d  = ~req_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_q   <= CFG_RST;
      req_q    <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      hold_q   <= hold_d;
      req_q    <= req_d;
      ack_s1_q <= link_ack_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  // Link side: take the snapshot, then apply it only at a frame boundary so that
  // no frame is sent with a mix of old and new widths.
  logic      req_s1_q, req_s2_q, req_s3_q;
  logic      link_ack_d;
  link_cfg_t cap_q, cap_d;
  link_cfg_t act_q, act_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [19:0] shreg_q, shreg_d;
  logic        fco_q, fco_d;
  logic        fst_q, fst_d;
  logic        last_bit;

  assign last_bit = (cnt_q >= act_q.width - 5'h01);

  always_comb begin
    link_ack_d = link_ack_q;
    cap_d      = cap_q;
    if (req_s3_q != link_ack_q) begin
      cap_d      = hold_q;
      link_ack_d = req_s3_q;
    end
    act_d   = act_q;
    cnt_d   = cnt_q + 5'h01;
    shreg_d = {shreg_q[18:0], 1'b0};
    fst_d   = 1'b0;
    if (last_bit) begin
      act_d   = cap_q;
      cnt_d   = 5'h00;
      shreg_d = sample_word;
      fst_d   = 1'b1;
    end
    if (act_d.auto_pattern) begin
      fco_d = (cnt_d < {1'b0, act_d.width[4:1]});
    end else begin
      fco_d = act_d.frame_clock_pattern[PAT_MSB - cnt_d];
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      req_s1_q   <= 1'b0;
      req_s2_q   <= 1'b0;
      req_s3_q   <= 1'b0;
      link_ack_q <= 1'b0;
      cap_q      <= CFG_RST;
      act_q      <= CFG_RST;
      cnt_q      <= 5'h00;
      shreg_q    <= 20'h00000;
      fco_q      <= 1'b0;
      fst_q      <= 1'b0;
    end else begin
      req_s1_q   <= req_q;
      req_s2_q   <= req_s1_q;
      req_s3_q   <= req_s2_q;
      link_ack_q <= link_ack_d;
      cap_q      <= cap_d;
      act_q      <= act_d;
      cnt_q      <= cnt_d;
      shreg_q    <= shreg_d;
      fco_q      <= fco_d;
      fst_q      <= fst_d;
    end
  end

  assign serial_data        = shreg_q[19];
  assign frame_clock_out    = fco_q;
  assign frame_start        = fst_q;
  assign half_drive_current = act_q.half_drive_current;
  assign lane_data_skew     = act_q.lane_data_skew;
  assign bit_clock_skew     = act_q.bit_clock_skew;

  // Checks, system domain.
  sequence s_wb_take;
    wb_cyc && wb_stb && !ack_q;
  endsequence

  sequence s_wr_idx(logic [5:0] i);
    wr_en && (idx == i);
  endsequence

  a_ack_single: assert property (@(posedge clk) disable iff (reset)
    s_wb_take |=> ack_q ##1 !ack_q)
    else $error("Bus ack not a single cycle after request.");
  a_wide_width: assert property (@(posedge clk) disable iff (reset)
    wide_q |-> cfg_now.width == 5'h14)
    else $error("Wide output does not give 20 bits.");
  a_bypass_resize: assert property (@(posedge clk) disable iff (reset)
    (decim_mode == DECIM_BYPASS) && !wide_q && resize_q && (wsel_q == 3'h1)
      |-> cfg_now.width == 5'h10)
    else $error("Bypass resize to 16 bits not applied.");
  a_bypass_native: assert property (@(posedge clk) disable iff (reset)
    (decim_mode == DECIM_BYPASS) && !wide_q && !resize_q |-> cfg_now.width == 5'h0E)
    else $error("Bypass width changed without resize enable.");
  a_wsel_decode: assert property (@(posedge clk) disable iff (reset)
    (decim_mode != DECIM_BYPASS) && !wide_q && (wsel_q == 3'h0) |-> cfg_now.width == 5'h12)
    else $error("Width code 000 does not give 18 bits.");
  a_pat_high: assert property (@(posedge clk) disable iff (reset)
    s_wr_idx(IDX_PAT_HI) |=> pat_q[19:16] == $past(wb_wdata[3:0])
      && pat_q[15:0] == $past(pat_q[15:0]))
    else $error("Frame pattern high nibble not written.");
  a_half_drive: assert property (@(posedge clk) disable iff (reset)
    s_wr_idx(IDX_DRIVE) |=> half_q == $past(wb_wdata[6]))
    else $error("Half drive bit not written.");
  a_skew_write: assert property (@(posedge clk) disable iff (reset)
    s_wr_idx(IDX_SKEW) |=> lskew_q == $past(wb_wdata[3:2]) && cskew_q == $past(wb_wdata[1:0]))
    else $error("Skew fields not written.");
  a_cross_done: assert property (@(posedge clk) disable iff (reset)
    $rose(busy) |-> ##[1:20] !busy)
    else $error("Configuration crossing did not complete.");

  // Checks, link domain.
  a_auto_frame: assert property (@(posedge link_clk) disable iff (reset)
    fst_q && act_q.auto_pattern |-> fco_q ##1 (act_q.width != 5'h0E || fco_q))
    else $error("Automatic frame clock not high at frame start.");
  a_pattern_msb: assert property (@(posedge link_clk) disable iff (reset)
    fst_q && !act_q.auto_pattern |-> fco_q == act_q.frame_clock_pattern[19])
    else $error("Frame clock does not follow pattern MSB.");
  a_frame_len: assert property (@(posedge link_clk) disable iff (reset)
    fst_q |-> cnt_q == 5'h00 && $past(cnt_q) == $past(act_q.width) - 5'h01)
    else $error("Frame start not after a full frame.");

endmodule
`default_nettype wire

/* dv/link_receiver.sv */
// Purpose: Receiver model that deserializes the sample link frame by frame.
// Assumes: Frame start marks bit 0; data arrives most significant bit first.
// Notes:   Outputs hold the last complete frame, right aligned.
`default_nettype none
module link_receiver (
  // Link side
  input  wire logic        link_clk,
  input  wire logic        reset,
  input  wire logic        serial_data,
  input  wire logic        frame_clock_out,
  input  wire logic        frame_start,
  // Last frame seen
  output logic      [19:0] word_q,
  output logic      [19:0] fco_q,
  output logic      [4:0]  len_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [19:0] acc_q;
  logic [19:0] fac_q;
  logic [4:0]  n_q;
  // A new frame restarts the accumulators, so bits of a longer frame never leak in.
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      {acc_q, fac_q, n_q, word_q, fco_q, len_q} <= '0;
    end else if (frame_start) begin
      word_q <= acc_q;
      fco_q  <= fac_q;
      len_q  <= n_q;
      acc_q  <= {19'h00000, serial_data};
      fac_q  <= {19'h00000, frame_clock_out};
      n_q    <= 5'h01;
    end else begin
      acc_q <= {acc_q[18:0], serial_data};
      fac_q <= {fac_q[18:0], frame_clock_out};
      n_q   <= n_q + 5'h01;
    end
  end
endmodule
`default_nettype wire

/* dv/adc_out_fmt_regs_tb_top.sv */
// Purpose: Self-checking bench for the output format registers and link framer.
// Assumes: Registers reached by classic Wishbone; link clock free of the bus clock.
// Notes:   Each format is checked on a frame sent wholly after the change.
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module adc_out_fmt_regs_tb_top
  import adc_out_fmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdata = '0, wb_rdata;
  decim_mode_t decim_mode = DECIM_BYPASS;
  logic [19:0] sample_word = 20'hA5C3B, word_q, fco_q;
  logic [4:0] len_q;
  logic serial_data, frame_clock_out, frame_start, half_drive_current;
  logic [1:0] lane_data_skew, bit_clock_skew;
  int errors = 0, checked = 0;
  always #2 clk = ~clk;
  initial begin
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end
  adc_out_fmt_regs adc_out_fmt_regs_inst (.clk(clk), .reset(reset), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
    .wb_rdata(wb_rdata), .wb_ack(wb_ack), .decim_mode(decim_mode), .link_clk(link_clk),
    .sample_word(sample_word), .serial_data(serial_data), .frame_clock_out(frame_clock_out),
    .frame_start(frame_start), .half_drive_current(half_drive_current),
    .lane_data_skew(lane_data_skew), .bit_clock_skew(bit_clock_skew));
  link_receiver link_receiver_inst (.link_clk(link_clk), .reset(reset),
    .serial_data(serial_data), .frame_clock_out(frame_clock_out), .frame_start(frame_start),
    .word_q(word_q), .fco_q(fco_q), .len_q(len_q));
  task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] d,
                      input logic [3:0] sel, output logic [31:0] rd);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'h0};
    wb_sel <= sel;
    wb_wdata <= {24'h000000, d};
    // No cycle count is assumed here; the watchdog ends a bus that never answers.
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    rd = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    xfer(1'b1, idx, d, 4'hF, rd);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] ex);
    logic [31:0] rd;
    xfer(1'b0, idx, 8'h00, 4'hF, rd);
    `CHK("register read", {24'h000000, ex}, rd)
  endtask
  // The change may land mid-frame, so the fourth boundary closes a clean frame.
  task automatic settle();
    repeat (4) @(posedge link_clk iff frame_start === 1'b1);
    #1;
  endtask
  task automatic fmt(input decim_mode_t m, input logic [7:0] r, input logic [19:0] pat,
                     input logic [4:0] w);
    logic [19:0] ef;
    int h;
    h = w / 2;
    ef = (m == DECIM_BYPASS) ? ((20'h00001 << h) - 20'h00001) << (w - h) : pat >> (20 - w);
    @(posedge clk);
    decim_mode <= m;
    wr(IDX_RES, r);
    wr(IDX_PAT_LO, pat[7:0]);
    wr(IDX_PAT_MID, pat[15:8]);
    wr(IDX_PAT_HI, {4'h0, pat[19:16]});
    rdc(IDX_RES, r);
    rdc(IDX_PAT_HI, {4'h0, pat[19:16]});
    settle();
    `CHK("frame length", w, len_q)
    `CHK("frame data", sample_word >> (20 - w), word_q)
    `CHK("frame clock", ef, fco_q)
    rdc(IDX_STATUS, {3'h0, w});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] rd;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rdc(IDX_DRIVE, 8'h00);
    rdc(IDX_RES, 8'h00);
    rdc(IDX_SKEW, 8'h00);
    rdc(IDX_PAT_LO, 8'h00);
    rdc(6'h10, 8'h00);
    xfer(1'b1, IDX_DRIVE, 8'h40, 4'hE, rd);
    rdc(IDX_DRIVE, 8'h00);
    wr(IDX_DRIVE, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_SKEW, 8'(i * 4 + 3 - i));
      settle();
      `CHK("lane skew", 2'(i), lane_data_skew)
      `CHK("bit clock skew", 2'(3 - i), bit_clock_skew)
      `CHK("half drive", 1'b1, half_drive_current)
    end
    fmt(DECIM_BYPASS, 8'h00, 20'h00000, WIDTH_14);
    fmt(DECIM_BYPASS, 8'h80, 20'h00000, WIDTH_18);
    fmt(DECIM_BYPASS, 8'h88, 20'h00000, WIDTH_16);
    fmt(DECIM_BYPASS, 8'h90, 20'h00000, WIDTH_14);
    fmt(DECIM_BYPASS, 8'h40, 20'h00000, WIDTH_20);
    fmt(DECIM_REAL, 8'h08, 20'hFF000, WIDTH_16);
    fmt(DECIM_REAL, 8'h10, 20'hFE000, WIDTH_14);
    fmt(DECIM_REAL, 8'h40, 20'hFFC00, WIDTH_20);
    fmt(DECIM_COMPLEX, 8'h08, 20'hFFFFF, WIDTH_16);
    fmt(DECIM_REAL, 8'h00, 20'hFF800, WIDTH_18);
    // A second reset in mid-run must bring registers and link outputs back to idle.
    @(posedge clk);
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rdc(IDX_RES, 8'h00);
    `CHK("half drive after reset", 1'b0, half_drive_current)
    `CHK("lane skew after reset", 2'h0, lane_data_skew)
    fmt(DECIM_BYPASS, 8'h00, 20'h00000, WIDTH_14);
    tally_and_finish();
  end
endmodule
`default_nettype wire
